// ==== verilog/smb_dev.sv ====
// device end: slave byte engine with pointer, block modes and register port
`timescale 1ns/100ps
`default_nettype none
module smb_dev (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // two-wire link
   smb_if.dev bus,
   // register space port
   output logic wr_en_out,
   output logic [7:0] wr_addr_out,
   output logic [7:0] wr_data_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic rd_done_out
);
   // ************************************************************
   // helpers
   // ************************************************************
   // address lies in the implemented space
   function automatic logic in_space(input logic [7:0] a);
      in_space = (a <= smb_pkg::REG_TOP);
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   logic [2:0] scl_sy_q; // [0] first stage, [1] second, [2] previous
   logic [2:0] sda_sy_q; // same layout for data
   smb_pkg::smb_dev_st_t st_q; // link state
   logic [3:0] bit_q;      // bits seen in this byte
   logic [7:0] sh_q;       // shift register, rx and tx
   logic sda_oe_q;         // pulling data low
   logic addr_ph_q;        // next byte is an address byte
   logic rd_q;             // current direction is read
   logic [1:0] idx_q;      // write byte index, saturating
   logic [7:0] cmd_q;      // first byte of last write
   logic blk_q;            // block read request pending
   logic [7:0] base_q;     // base address for plain reads
   logic [7:0] ptr_q;      // working pointer
   logic [7:0] blk_addr_q; // block read start address
   logic [7:0] len_q;      // requested block read length
   logic cnt_ph_q;         // next tx byte is the count
   logic wr_en_q;          // write strobe
   logic [7:0] wr_addr_q;  // write address
   logic [7:0] wr_data_q;  // write data
   logic rd_done_q;        // one data byte fully read

   // ************************************************************
   // decode
   // ************************************************************
   wire scl_s = scl_sy_q[1];
   wire scl_p = scl_sy_q[2];
   wire sda_s = sda_sy_q[1];
   wire sda_p = sda_sy_q[2];
   wire scl_rise = scl_s & ~scl_p;
   wire scl_fall = ~scl_s & scl_p;
   wire start_det = scl_s & scl_p & sda_p & ~sda_s; // data falls, clock high
   wire stop_det = scl_s & scl_p & ~sda_p & sda_s;  // data rises, clock high
   wire byte_done = (st_q == smb_pkg::ST_RX) & scl_fall & (bit_q == smb_pkg::BITS_BYTE);
   wire addr_hit = (sh_q[7:1] == smb_pkg::SLAVE_ADDR);
   wire is_f0 = (cmd_q == smb_pkg::CMD_BLK_WR);
   wire is_f1 = (cmd_q == smb_pkg::CMD_BLK_RD);
   wire [1:0] idx_inc = (idx_q == smb_pkg::IDX_MAX) ? idx_q : idx_q + 2'h1;
   wire [7:0] ptr_inc = (ptr_q == smb_pkg::ADDR_MAX) ? ptr_q : ptr_q + 8'h01;
   // data bytes: after address in f0, none in f1, after register address otherwise
   wire data_wr = is_f0 ? (idx_q == smb_pkg::IDX_MAX) : (~is_f1 & (idx_q != 2'h0));
   wire wr_byte = byte_done & ~addr_ph_q & ~rd_q;
   wire tx_end = (st_q == smb_pkg::ST_TX) & scl_fall & (bit_q == smb_pkg::BITS_BYTE);
   // count first in block read, zero outside the space
   wire [7:0] tx_byte = cnt_ph_q ? len_q :
                        (in_space(ptr_q) ? rd_data_in : smb_pkg::RD_NONE);

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe = sda_oe_q;
   assign wr_en_out = wr_en_q;
   assign wr_addr_out = wr_addr_q;
   assign wr_data_out = wr_data_q;
   assign rd_addr_out = ptr_q;
   assign rd_done_out = rd_done_q;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // link pins are foreign to this clock; third stage only for edges
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         scl_sy_q <= 3'h7;
         sda_sy_q <= 3'h7;
      end else begin
         scl_sy_q <= {scl_sy_q[1:0], bus.scl};
         sda_sy_q <= {sda_sy_q[1:0], bus.sda};
      end
   end

   // ************************************************************
   // bit engine
   // ************************************************************
   // start and stop win over everything, so a torn byte is dropped
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         st_q <= smb_pkg::ST_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         sda_oe_q <= 1'b0;
      end else if (start_det) begin
         st_q <= smb_pkg::ST_RX;
         bit_q <= 4'h0;
         sda_oe_q <= 1'b0;
      end else if (stop_det) begin
         st_q <= smb_pkg::ST_IDLE;
         sda_oe_q <= 1'b0;
      end else begin
         case (st_q)
            smb_pkg::ST_RX: begin
               // sample on rise, judge the byte on the eighth fall
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_s};
                  bit_q <= bit_q + 4'h1;
               end else if (byte_done) begin
                  bit_q <= 4'h0;
                  if (addr_ph_q & ~addr_hit) begin
                     st_q <= smb_pkg::ST_IDLE;
                  end else begin
                     st_q <= smb_pkg::ST_ACK;
                     sda_oe_q <= 1'b1;
                  end
               end
            end
            smb_pkg::ST_ACK, smb_pkg::ST_LOAD: begin
               // end of ack clock: load tx byte or go back to rx
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (rd_q) begin
                     st_q <= smb_pkg::ST_TX;
                     sh_q <= {tx_byte[6:0], 1'b0};
                     sda_oe_q <= ~tx_byte[7];
                  end else begin
                     st_q <= smb_pkg::ST_RX;
                     sda_oe_q <= 1'b0;
                  end
               end
            end
            smb_pkg::ST_TX: begin
               // next bit goes out on each fall, msb first
               if (scl_rise) begin
                  bit_q <= bit_q + 4'h1;
               end else if (tx_end) begin
                  st_q <= smb_pkg::ST_MACK;
                  sda_oe_q <= 1'b0;
               end else if (scl_fall) begin
                  sda_oe_q <= ~sh_q[7];
                  sh_q <= {sh_q[6:0], 1'b0};
               end
            end
            smb_pkg::ST_MACK: begin
               // high data on the ack clock means done, stay off the line
               if (scl_rise) begin
                  st_q <= sda_s ? smb_pkg::ST_IDLE : smb_pkg::ST_LOAD;
               end
            end
            smb_pkg::ST_IDLE: begin
               st_q <= smb_pkg::ST_IDLE; // wait for a start
            end
            default: begin
               st_q <= smb_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // transaction registers
   // ************************************************************
   // address byte, command decode and pointer handling
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         addr_ph_q <= 1'b1;
         rd_q <= 1'b0;
         idx_q <= 2'h0;
         cmd_q <= 8'h00;
         blk_q <= 1'b0;
         base_q <= 8'h00;
         ptr_q <= 8'h00;
         blk_addr_q <= 8'h00;
         len_q <= 8'h00;
         cnt_ph_q <= 1'b0;
      end else if (start_det) begin
         addr_ph_q <= 1'b1; // every transaction opens with an address
      end else if (byte_done & addr_ph_q & addr_hit) begin
         rd_q <= sh_q[0];
         addr_ph_q <= 1'b0;
         idx_q <= 2'h0;
         if (sh_q[0]) begin
            cnt_ph_q <= blk_q;
            ptr_q <= blk_q ? blk_addr_q : base_q;
         end
      end else if (wr_byte) begin
         idx_q <= idx_inc;
         if (idx_q == 2'h0) begin
            cmd_q <= sh_q;
            blk_q <= (sh_q == smb_pkg::CMD_BLK_RD);
            if ((sh_q != smb_pkg::CMD_BLK_WR) && (sh_q != smb_pkg::CMD_BLK_RD)) begin
               base_q <= sh_q;
               ptr_q <= sh_q;
            end
         end else if (is_f0 & (idx_q == 2'h2)) begin
            ptr_q <= sh_q; // count at index one ignored
         end else if (is_f1 & (idx_q == 2'h2)) begin
            blk_addr_q <= sh_q;
         end else if (is_f1 & (idx_q == smb_pkg::IDX_MAX)) begin
            len_q <= sh_q; // length kept as sent, not checked
         end else if (data_wr) begin
            ptr_q <= ptr_inc;
         end
      end else if (tx_end) begin
         // count byte does not move the pointer
         if (cnt_ph_q) begin
            cnt_ph_q <= 1'b0;
         end else begin
            ptr_q <= ptr_inc;
         end
      end
   end

   // ************************************************************
   // register port strobes
   // ************************************************************
   // strobes only for whole bytes, so reads never clear on a torn byte
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wr_en_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
         rd_done_q <= 1'b0;
      end else begin
         wr_en_q <= wr_byte & data_wr & in_space(ptr_q);
         rd_done_q <= tx_end & ~cnt_ph_q;
         if (wr_byte & data_wr) begin
            wr_addr_q <= ptr_q;
            wr_data_q <= sh_q;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/smb_pkg.sv ====
// shared constants and types for the serial register-port engine
package smb_pkg;
   // ************************************************************
   // bus-level constants
   // ************************************************************
   localparam logic [6:0] SLAVE_ADDR = 7'h2c; // 7-bit bus address, a plain default
   localparam logic [7:0] CMD_BLK_WR = 8'hf0; // block write command
   localparam logic [7:0] CMD_BLK_RD = 8'hf1; // block read request command
   localparam logic [7:0] REG_TOP = 8'hef;    // last implemented register
   localparam logic [7:0] ADDR_MAX = 8'hff;   // pointer saturation limit
   localparam logic [7:0] RD_NONE = 8'h00;    // value read outside the space
   localparam logic [1:0] IDX_MAX = 2'h3;     // byte index saturates here
   localparam logic [3:0] BITS_BYTE = 4'h8;   // data bits per byte

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS = 40;  // system clock period
   localparam int QTR_NS = 160; // quarter of one link bit, driven by the host
   localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS; // least time, round up
   localparam logic [3:0] QTR_LAST = 4'(QTR_CYC - 1);      // divider wrap value

   // ************************************************************
   // host command stream
   // ************************************************************
   localparam int OP_W = 3;             // op field width
   localparam int DATA_W = 8;           // data field width
   localparam int CMD_W = OP_W + DATA_W; // fifo word width
   localparam int FIFO_DEPTH = 4;       // fifo words

   typedef enum logic [2:0] {
      OP_START, OP_STOP, OP_WRITE, OP_READ_ACK, OP_READ_NACK
   } smb_op_t;

   // device link states
   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_LOAD
   } smb_dev_st_t;

   // host engine states
   typedef enum logic {H_IDLE, H_RUN} smb_host_st_t;
endpackage

// ==== verilog/smb_if.sv ====
// two-wire link between the host end and the device end
`timescale 1ns/100ps
`default_nettype none
interface smb_if;
   logic scl;         // clock, host only, no stretching
   logic host_sda_o;  // host data value (always low)
   logic host_sda_oe; // host pulls data low
   logic dev_sda_o;   // device data value (always low)
   logic dev_sda_oe;  // device pulls data low
   logic sda;         // resolved wired-and data line

   // open-drain line with a pull-up: high unless someone pulls low
   assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

   modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
   modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ==== verilog/smb_host.sv ====
// host end: command fifo and a bus master bit engine
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// command fifo
// ************************************************************
// pointers wrap naturally, so depth must be a power of two
module smb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
   logic [AW-1:0] wp_q;            // write index
   logic [AW-1:0] rp_q;            // read index
   logic [AW:0] cnt_q;             // words held
   wire push = in_valid_in & in_ready_out;
   wire pop = out_valid_out & out_ready_in;
   wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_data_out = mem_q[rp_q];

   // storage, no reset needed on data
   always_ff @(posedge clk_sys_in) begin
      if (push) begin
         mem_q[wp_q] <= in_data_in;
      end
   end

   // indices and registered flags
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         in_ready_out <= 1'b0;
         out_valid_out <= 1'b0;
      end else begin
         wp_q <= push ? wp_q + {{(AW-1){1'b0}}, 1'b1} : wp_q;
         rp_q <= pop ? rp_q + {{(AW-1){1'b0}}, 1'b1} : rp_q;
         cnt_q <= cnt_d;
         in_ready_out <= (cnt_d != (AW+1)'(DEPTH));
         out_valid_out <= (cnt_d != '0);
      end
   end
endmodule

// ************************************************************
// host engine
// ************************************************************
module smb_host (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // two-wire link
   smb_if.host bus,
   // command stream
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic [smb_pkg::OP_W-1:0] cmd_op_in,
   input wire logic [7:0] cmd_data_in,
   // results
   output logic done_out,
   output logic [7:0] rdata_out,
   output logic rdata_valid_out,
   output logic nack_out
);
   logic [1:0] sda_sy_q;         // data pin synchroniser
   smb_pkg::smb_host_st_t hst_q; // engine state
   smb_pkg::smb_op_t op_q;       // op in progress
   logic [7:0] sh_q;             // shift register
   logic [3:0] bit_q;            // bit within byte, 0..8
   logic [1:0] qtr_q;            // quarter within bit
   logic [3:0] div_q;            // quarter divider
   logic scl_q;                  // clock drive
   logic sda_oe_q;               // pulling data low
   logic done_q;                 // op finished pulse
   logic rdv_q;                  // read byte pulse
   logic [7:0] rdata_q;          // last read byte
   logic nack_q;                 // last write not acknowledged
   logic fifo_valid;             // fifo word waiting
   logic [smb_pkg::CMD_W-1:0] fifo_data; // fifo head

   wire sda_s = sda_sy_q[1];
   wire idle = (hst_q == smb_pkg::H_IDLE);
   wire tick = (div_q == smb_pkg::QTR_LAST); // quarter enable
   wire is_start = (op_q == smb_pkg::OP_START);
   wire is_stop = (op_q == smb_pkg::OP_STOP);
   wire is_wr = (op_q == smb_pkg::OP_WRITE);
   wire is_byte = ~is_start & ~is_stop;
   wire last_bit = (bit_q == smb_pkg::BITS_BYTE);
   // data bits out on write, ack bit out on read
   wire bit_drive = is_wr ? (~last_bit & ~sh_q[7]) :
                    (last_bit & (op_q == smb_pkg::OP_READ_ACK));
   wire finish = tick & (qtr_q == 2'h3) & (~is_byte | last_bit);

   assign bus.scl = scl_q;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe = sda_oe_q;
   assign done_out = done_q;
   assign rdata_out = rdata_q;
   assign rdata_valid_out = rdv_q;
   assign nack_out = nack_q;

   // command buffer; drains only while the engine is idle
   smb_fifo #(.WIDTH(smb_pkg::CMD_W), .DEPTH(smb_pkg::FIFO_DEPTH)) u_fifo (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .in_valid_in(cmd_valid_in),
      .in_ready_out(cmd_ready_out),
      .in_data_in({cmd_op_in, cmd_data_in}),
      .out_valid_out(fifo_valid),
      .out_ready_in(idle),
      .out_data_out(fifo_data)
   );

   // data pin synchroniser and quarter divider
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         sda_sy_q <= 2'h3;
         div_q <= 4'h0;
      end else begin
         sda_sy_q <= {sda_sy_q[0], bus.sda};
         div_q <= (idle | tick) ? 4'h0 : div_q + 4'h1;
      end
   end

   // four quarters per bit: set data, raise clock, sample, drop clock
   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         hst_q <= smb_pkg::H_IDLE;
         op_q <= smb_pkg::OP_STOP;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         qtr_q <= 2'h0;
         scl_q <= 1'b1;
         sda_oe_q <= 1'b0;
         done_q <= 1'b0;
         rdv_q <= 1'b0;
         rdata_q <= 8'h00;
         nack_q <= 1'b0;
      end else begin
         done_q <= finish;
         rdv_q <= finish & is_byte & ~is_wr;
         if (idle) begin
            if (fifo_valid) begin
               hst_q <= smb_pkg::H_RUN;
               op_q <= smb_pkg::smb_op_t'(fifo_data[smb_pkg::CMD_W-1:smb_pkg::DATA_W]);
               sh_q <= fifo_data[7:0]; // address byte rides as a write
               bit_q <= 4'h0;
               qtr_q <= 2'h0;
            end
         end else if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            case (qtr_q)
               2'h0: begin
                  sda_oe_q <= is_start ? 1'b0 : (is_stop ? 1'b1 : bit_drive);
               end
               2'h1: begin
                  scl_q <= 1'b1;
               end
               2'h2: begin
                  // start pulls data low, stop lets it rise, clock high
                  if (is_start) begin
                     sda_oe_q <= 1'b1;
                  end else if (is_stop) begin
                     sda_oe_q <= 1'b0;
                  end else if (~last_bit) begin
                     sh_q <= {sh_q[6:0], sda_s};
                  end else if (is_wr) begin
                     nack_q <= sda_s;
                  end
               end
               default: begin
                  scl_q <= is_stop; // clock rests high after stop
                  bit_q <= bit_q + 4'h1;
                  if (finish) begin
                     hst_q <= smb_pkg::H_IDLE;
                     if (is_byte & ~is_wr) begin
                        rdata_q <= sh_q;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ==== verification/smb_link_props.sv ====
// wire-level checks on the two-wire link between both ends
`timescale 1ns/100ps
`default_nettype none
module smb_link_props (
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // link signals
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   // ****************************************
   // framing events, only the host may make them; device data timing and clock high and low times
   // ****************************************
   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   a_dev_quiet_high: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device moved data while clock high");
   a_pull_late: assert property ($rose(dev_sda_oe) |-> !$past(scl) && !$past(scl, 2))
      else $error("device pull too soon after clock fall");
   a_release_late: assert property ($fell(dev_sda_oe) |-> !$past(scl) && !$past(scl, 2))
      else $error("device release too soon after clock fall");
   a_bit_held: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*4])
      else $error("device bit not held over clock high");
   a_start_host: assert property (s_start |-> host_sda_oe && !dev_sda_oe)
      else $error("start not made by host");
   a_stop_free: assert property (s_stop |-> !dev_sda_oe [*4])
      else $error("device pulls after stop");
   a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high too short");
   a_scl_low_min: assert property ($fell(scl) |=> !scl [*3])
      else $error("clock low too short");
endmodule
`default_nettype wire

// ==== verification/smbus_slave_block_transfer_bench.sv ====
// self-checking bench: host end drives device end over the link
`timescale 1ns/100ps
`default_nettype none
module smbus_slave_block_transfer_bench;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic cmd_valid = 1'b0;
   logic [2:0] cmd_op = 3'h0;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ready, done, rdata_valid, nack, wr_en, rd_done;
   logic [7:0] rdata, wr_addr, wr_data, rd_addr;
   logic [7:0] mem [256]; // register space behind the device
   logic [7:0] sh [256]; // expected contents
   logic [15:0] wq [$]; // expected writes {addr,data}
   logic [7:0] rq [$]; // expected read bytes
   int mismatches = 0;
   int checked = 0;
   int npush = 0;
   int ndone = 0;
   int nrd = 0; // whole data bytes shifted out by the device
   logic [7:0] b;
   wire [7:0] rd_data = mem[rd_addr]; // combinational read port
   smb_if bus ();
   smb_host i_smb_host (.clk_sys_in, .rst_in, .bus(bus.host), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data),
      .done_out(done), .rdata_out(rdata), .rdata_valid_out(rdata_valid), .nack_out(nack));
   smb_dev i_smb_dev (.clk_sys_in, .rst_in, .bus(bus.dev), .wr_en_out(wr_en),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data), .rd_addr_out(rd_addr),
      .rd_data_in(rd_data), .rd_done_out(rd_done));
   smb_link_props i_smb_link_props (.clk_sys_in, .rst_in, .scl(bus.scl), .sda(bus.sda),
      .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe));
   always #20 clk_sys_in = ~clk_sys_in;
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // push one op; the fifo stalls us when full
   task automatic op(input smb_pkg::smb_op_t o, input logic [7:0] d);
      @(negedge clk_sys_in);
      while (cmd_ready !== 1'b1) @(negedge clk_sys_in);
      cmd_valid = 1'b1;
      cmd_op = o;
      cmd_data = d;
      @(negedge clk_sys_in);
      cmd_valid = 1'b0;
      npush++;
   endtask
   task automatic wr(input logic [7:0] d);
      op(smb_pkg::OP_WRITE, d);
   endtask
   task automatic hdr(input logic rw);
      op(smb_pkg::OP_START, 8'h00);
      wr({smb_pkg::SLAVE_ADDR, rw});
   endtask
   task automatic rd(input logic ack, input logic [7:0] e);
      op(ack ? smb_pkg::OP_READ_ACK : smb_pkg::OP_READ_NACK, 8'h00);
      rq.push_back(e);
   endtask
   // stop, wait for all ops, then expect no leftover notes
   task automatic fin(input string name);
      int n;
      op(smb_pkg::OP_STOP, 8'h00);
      n = 0;
      while (ndone != npush && n < 20000) begin
         @(posedge clk_sys_in);
         n++;
      end
      if (n >= 20000) begin
         mismatches++;
         $display("wrong value at %0t: ops never finished", $time);
      end
      chk({15'h0, wq.size() == 0 && rq.size() == 0}, 16'h0001);
      $display("test %s done", name);
   endtask
   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge clk_sys_in) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
         chk({wr_addr, wr_data}, wq.size() ? wq.pop_front() : 16'hxxxx);
      end
      if (rdata_valid) chk({8'h00, rdata}, rq.size() ? {8'h00, rq.pop_front()} : 16'hxxxx);
      if (done) ndone++;
      if (rd_done) nrd++;
   end
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      mismatches++;
      $display("wrong value at %0t: watchdog expired", $time);
      conclude();
   end
   initial begin
      void'($urandom(72));
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($urandom);
         sh[i] = mem[i];
      end
      repeat (6) @(negedge clk_sys_in);
      rst_in = 1'b0;
      repeat (2) @(negedge clk_sys_in);
      hdr(1'b0);
      wr(8'hee);
      for (int i = 0; i < 3; i++) begin
         b = 8'($urandom);
         wr(b);
         if (8'(8'hee + i) <= smb_pkg::REG_TOP) wq.push_back({8'(8'hee + i), b});
         if (8'(8'hee + i) <= smb_pkg::REG_TOP) sh[8'hee + i] = b;
      end
      fin("plain block write");
      hdr(1'b0);
      wr(smb_pkg::CMD_BLK_WR);
      wr(8'h01);
      wr(8'hc0);
      for (int i = 0; i < 35; i++) begin
         b = 8'($urandom);
         wr(b);
         wq.push_back({8'(8'hc0 + i), b});
         sh[8'hc0 + i] = b;
      end
      fin("long block write");
      hdr(1'b0);
      wr(8'hc5);
      hdr(1'b1);
      rd(1'b0, sh[8'hc5]);
      fin("read byte");
      hdr(1'b0);
      wr(8'hc7);
      hdr(1'b1);
      rd(1'b1, sh[8'hc7]);
      rd(1'b0, sh[8'hc8]);
      fin("read word");
      hdr(1'b1);
      rd(1'b0, sh[8'hc7]);
      fin("repeat read");
      chk({15'h0, nack}, 16'h0000);
      op(smb_pkg::OP_START, 8'h00);
      wr({smb_pkg::SLAVE_ADDR ^ 7'h01, 1'b0});
      fin("foreign address");
      chk({15'h0, nack}, 16'h0001);
      hdr(1'b0);
      wr(smb_pkg::CMD_BLK_RD);
      wr(8'h02);
      wr(8'hee);
      wr(8'h03);
      hdr(1'b1);
      rd(1'b1, 8'h03);
      rd(1'b1, sh[8'hee]);
      rd(1'b1, sh[8'hef]);
      rd(1'b1, smb_pkg::RD_NONE);
      rd(1'b0, smb_pkg::RD_NONE);
      fin("block read");
      hdr(1'b1);
      rd(1'b0, 8'h03);
      fin("aborted block read");
      hdr(1'b0);
      wr(8'hc5);
      fin("bus after abort");
      chk({15'h0, nack}, 16'h0000);
      // writes past the top: no strobe may appear, pointer must rest at the limit
      hdr(1'b0);
      wr(8'hfe);
      for (int i = 0; i < 3; i++) begin
         wr(8'($urandom));
      end
      fin("saturating write");
      chk({8'h00, rd_addr}, {8'h00, smb_pkg::ADDR_MAX});
      // one strobe per data byte read, none for count bytes
      chk(16'(nrd), 16'h0008);
      conclude();
   end
endmodule
`default_nettype wire
